//--- hw/qawfc_top.sv
`timescale 1ns/1ps
`include "qawfc_consts.svh"
module qawfc_top (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RESET,
  input  wire logic [2:0] I_DEV_STATE,
  input  wire logic       I_CORRECT_ANSWER,
  input  wire logic       I_WRONG_ANSWER,
  input  wire logic       I_TIME_OUT,
  input  wire logic       I_CFG_CHANGE,
  input  wire logic       I_ANSWER_MODE_SEL,
  input  wire logic       I_SAFING_DRIVE_ENABLE,
  input  wire logic       I_RESET_ON_FAIL_ENABLE,
  input  wire logic       I_SAFE_EXIT,
  input  wire logic       I_SAFING_TH_WR,
  input  wire logic [3:0] I_SAFING_TH_DATA,
  input  wire logic       I_RESET_TH_WR,
  input  wire logic [3:0] I_RESET_TH_DATA,
  input  wire logic       I_CHALLENGE_RD,
  input  wire logic       I_SPI_FAULT,
  input  wire logic [3:0] I_CHALLENGE_VALUE,
  input  wire logic       I_WIN1_ENTER,
  input  wire logic       I_RESPONSE_WR,
  input  wire logic [7:0] I_RESPONSE_BYTE,
  input  wire logic       I_NO_ANSWER_CLR,
  output logic      [3:0] O_FAILURE_TALLY,
  output logic      [3:0] O_SAFING_THRESHOLD,
  output logic      [3:0] O_RESET_THRESHOLD,
  output logic            O_FAIL_SEEN_FLAG,
  output logic            O_SAFING_FAIL_FLAG,
  output logic            O_RESET_FAIL_FLAG,
  output logic            O_NO_ANSWER_FLAG,
  output logic            O_SAFING_DRIVE_PIN,
  output logic            O_MCU_RESET_N_PIN,
  output logic      [1:0] O_STATE_REQ,
  output logic            O_NEW_RUN,
  output logic            O_QUESTION_EVENT,
  output logic      [3:0] O_CHALLENGE_VALUE,
  output logic      [1:0] O_RESPONSE_COUNTDOWN,
  output logic     [31:0] O_RESPONSE_WORD,
  output logic            O_FINAL_BYTE
);

  logic [3:0]  tally_r;
  logic [3:0]  tally_nxt;
  logic [3:0]  safing_th_r;
  logic [3:0]  reset_th_r;
  logic        fail_seen_r;
  logic        no_answer_r;
  logic        new_run_r;
  logic        question_r;
  logic [3:0]  challenge_r;
  logic [1:0]  countdown_r;
  logic [31:0] resp_word_r;
  logic        final_r;
  logic        upd_ok;
  logic        inc_ev;
  logic        dec_ev;
  logic        in_diag;
  logic        at_rst_th;
  logic        reset_hit_r;

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == `QAWFC_TALLY_MAX) ? v : v + `QAWFC_STEP;
  endfunction

  function automatic logic [3:0] sat_dec(input logic [3:0] v);
    sat_dec = (v == `QAWFC_TALLY_MIN) ? v : v - `QAWFC_STEP;
  endfunction

  // state gate for tally updates
  assign upd_ok = (I_DEV_STATE == 3'(qawfc_pkg::QAWFC_ST_DIAG)) ||
                  (I_DEV_STATE == 3'(qawfc_pkg::QAWFC_ST_ACTIVE)) ||
                  (I_DEV_STATE == 3'(qawfc_pkg::QAWFC_ST_SAFE));
  assign in_diag = (I_DEV_STATE == 3'(qawfc_pkg::QAWFC_ST_DIAG));
  // wrong answer, time-out or config change each count one step
  assign inc_ev = I_WRONG_ANSWER || I_TIME_OUT || I_CFG_CHANGE;
  assign dec_ev = I_CORRECT_ANSWER && !inc_ev;

  always_comb begin
    tally_nxt = tally_r;
    if (I_SAFING_TH_WR && in_diag) begin
      tally_nxt = I_SAFING_TH_DATA;
    end else if (upd_ok && inc_ev) begin
      tally_nxt = sat_inc(tally_r);
    end else if (upd_ok && dec_ev) begin
      tally_nxt = sat_dec(tally_r);
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      tally_r <= `QAWFC_TALLY_RST;
    end else begin
      tally_r <= tally_nxt;
    end
  end

  // thresholds writable in diagnostic only
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      safing_th_r <= `QAWFC_TALLY_RST;
      reset_th_r  <= `QAWFC_TALLY_MAX;
    end else begin
      if (I_SAFING_TH_WR && in_diag) begin
        safing_th_r <= I_SAFING_TH_DATA;
      end
      if (I_RESET_TH_WR && in_diag) begin
        reset_th_r <= I_RESET_TH_DATA;
      end
    end
  end

  // fail-seen: set on increment, cleared once tally is back to zero
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      fail_seen_r <= 1'b0;
    end else if (upd_ok && inc_ev && tally_r != `QAWFC_TALLY_MAX) begin
      fail_seen_r <= 1'b1;
    end else if (tally_r == `QAWFC_TALLY_MIN) begin
      fail_seen_r <= 1'b0;
    end
  end

  // no-answer flag: set wins over clear
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      no_answer_r <= 1'b0;
    end else if (upd_ok && I_TIME_OUT) begin
      no_answer_r <= 1'b1;
    end else if (I_NO_ANSWER_CLR) begin
      no_answer_r <= 1'b0;
    end
  end

  assign at_rst_th = (tally_r == reset_th_r);

  // one-cycle state request on reaching the reset threshold
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      reset_hit_r <= 1'b0;
      O_STATE_REQ <= 2'(qawfc_pkg::QAWFC_GO_NONE);
    end else begin
      reset_hit_r <= at_rst_th;
      O_STATE_REQ <= 2'(qawfc_pkg::QAWFC_GO_NONE);
      if (at_rst_th && upd_ok) begin
        if (I_RESET_ON_FAIL_ENABLE &&
            (!reset_hit_r || I_SAFE_EXIT) &&
            (I_DEV_STATE != 3'(qawfc_pkg::QAWFC_ST_SAFE) || I_SAFE_EXIT)) begin
          O_STATE_REQ <= 2'(qawfc_pkg::QAWFC_GO_RESET);
        end else if (!I_RESET_ON_FAIL_ENABLE && !reset_hit_r &&
                     I_DEV_STATE != 3'(qawfc_pkg::QAWFC_ST_SAFE)) begin
          O_STATE_REQ <= 2'(qawfc_pkg::QAWFC_GO_SAFE);
        end
      end
    end
  end

  // status and pins from flops
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_SAFING_FAIL_FLAG <= 1'b1;
      O_RESET_FAIL_FLAG  <= 1'b0;
      O_SAFING_DRIVE_PIN <= 1'b0;
      O_MCU_RESET_N_PIN  <= 1'b1;
    end else begin
      O_SAFING_FAIL_FLAG <= (tally_r >= safing_th_r);
      O_RESET_FAIL_FLAG  <= at_rst_th;
      O_SAFING_DRIVE_PIN <= I_SAFING_DRIVE_ENABLE && (tally_r < safing_th_r);
      O_MCU_RESET_N_PIN  <= !(I_RESET_ON_FAIL_ENABLE && at_rst_th);
    end
  end

  // new run after time-out, config change or final byte
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      new_run_r <= 1'b0;
    end else begin
      new_run_r <= I_TIME_OUT || I_CFG_CHANGE || final_r;
    end
  end

  // question event unless the frame faulted
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      question_r  <= 1'b0;
      challenge_r <= 4'h0;
    end else begin
      question_r <= I_CHALLENGE_RD && !I_SPI_FAULT;
      if (I_CHALLENGE_RD && !I_SPI_FAULT) begin
        challenge_r <= I_CHALLENGE_VALUE;
      end
    end
  end

  // response byte countdown and word assembly
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      countdown_r <= `QAWFC_CNT_MULTI;
      resp_word_r <= 32'h0000_0000;
      final_r     <= 1'b0;
    end else begin
      final_r <= 1'b0;
      if (I_ANSWER_MODE_SEL) begin
        countdown_r <= `QAWFC_CNT_SINGLE;
        if (I_RESPONSE_WR) begin
          resp_word_r <= {24'h00_0000, I_RESPONSE_BYTE};
          final_r     <= 1'b1;
        end
      end else if (I_WIN1_ENTER) begin
        countdown_r <= `QAWFC_CNT_MULTI;
      end else if (I_RESPONSE_WR) begin
        // byte 3 first down to byte 0
        resp_word_r <= {resp_word_r[23:0], I_RESPONSE_BYTE};
        if (countdown_r == `QAWFC_CNT_ZERO) begin
          final_r <= 1'b1;
        end else begin
          countdown_r <= countdown_r - `QAWFC_CNT_STEP;
        end
      end
    end
  end

  assign O_FAILURE_TALLY      = tally_r;
  assign O_SAFING_THRESHOLD   = safing_th_r;
  assign O_RESET_THRESHOLD    = reset_th_r;
  assign O_FAIL_SEEN_FLAG     = fail_seen_r;
  assign O_NO_ANSWER_FLAG     = no_answer_r;
  assign O_NEW_RUN            = new_run_r;
  assign O_QUESTION_EVENT     = question_r;
  assign O_CHALLENGE_VALUE    = challenge_r;
  assign O_RESPONSE_COUNTDOWN = countdown_r;
  assign O_RESPONSE_WORD      = resp_word_r;
  assign O_FINAL_BYTE         = final_r;

  tally_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (!upd_ok && !I_SAFING_TH_WR) |=> $stable(tally_r))
    else $error("tally moved outside allowed states");

  inc_step_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (upd_ok && I_WRONG_ANSWER && !I_SAFING_TH_WR && tally_r != `QAWFC_TALLY_MAX)
      |=> tally_r == $past(tally_r) + `QAWFC_STEP)
    else $error("wrong answer did not raise tally");

  dec_step_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (upd_ok && dec_ev && !I_SAFING_TH_WR && tally_r != `QAWFC_TALLY_MIN)
      |=> tally_r == $past(tally_r) - `QAWFC_STEP)
    else $error("correct answer did not lower tally");

  ceil_sat_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (tally_r == `QAWFC_TALLY_MAX && !I_SAFING_TH_WR && !dec_ev)
      |=> tally_r == `QAWFC_TALLY_MAX)
    else $error("tally left ceiling");

  floor_sat_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (tally_r == `QAWFC_TALLY_MIN && !I_SAFING_TH_WR && !inc_ev)
      |=> tally_r == `QAWFC_TALLY_MIN)
    else $error("tally left floor");

  safing_low_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (tally_r >= safing_th_r) |=> (!O_SAFING_DRIVE_PIN && O_SAFING_FAIL_FLAG))
    else $error("safing not forced low");

  mcu_reset_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (I_RESET_ON_FAIL_ENABLE && at_rst_th) |=> !O_MCU_RESET_N_PIN)
    else $error("mcu reset not asserted");

  th_load_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (I_SAFING_TH_WR && in_diag) |=> tally_r == $past(I_SAFING_TH_DATA))
    else $error("tally not loaded with threshold");

  question_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (I_CHALLENGE_RD && I_SPI_FAULT) |=> !O_QUESTION_EVENT)
    else $error("question event on faulted frame");

  single_cnt_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    I_ANSWER_MODE_SEL |=> countdown_r == `QAWFC_CNT_SINGLE)
    else $error("single mode countdown not one");

  // first arrival at the reset threshold without reset-on-fail
  sequence thr_safe_s;
    at_rst_th && !reset_hit_r && upd_ok && !I_RESET_ON_FAIL_ENABLE &&
      (I_DEV_STATE != 3'(qawfc_pkg::QAWFC_ST_SAFE));
  endsequence

  // safe-exit command while parked at the reset threshold
  sequence exit_reset_s;
    at_rst_th && upd_ok && I_RESET_ON_FAIL_ENABLE && I_SAFE_EXIT;
  endsequence

  safe_req_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    thr_safe_s |=> O_STATE_REQ == 2'(qawfc_pkg::QAWFC_GO_SAFE))
    else $error("safe request missing");

  exit_reset_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    exit_reset_s |=> O_STATE_REQ == 2'(qawfc_pkg::QAWFC_GO_RESET))
    else $error("reset request after safe exit missing");

  win1_load_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (!I_ANSWER_MODE_SEL && I_WIN1_ENTER) |=> countdown_r == `QAWFC_CNT_MULTI)
    else $error("countdown not loaded on window one");

  fail_seen_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    (upd_ok && inc_ev && !I_SAFING_TH_WR && tally_r != `QAWFC_TALLY_MAX)
      |=> fail_seen_r)
    else $error("fail-seen not set on increment");

endmodule

//--- hw/qawfc_consts.svh
// Overview of operation
// - correct answer lowers the failure tally by one, floor at zero.
// - wrong answer raises the failure tally by one, ceiling applies.
// - missing or incomplete answer raises tally and sets no-answer flag.
// - mode, window length or answer config change raises tally by one.
// - tally changes only in diagnostic, active or safe state.
// - tally below safing threshold keeps safing output permitted.
// - safing output works only when safing-drive enable is set.
// - tally at or above safing threshold drives safing low, sets flag.
// - fail-seen flag sets on every increment; clears the cycle after tally reads zero.
// - reset-on-fail with tally at reset threshold pulls mcu reset low.
// - tally equal reset threshold sets reset-fail, enters reset or safe.
// - power-on reset loads tally with 0x05.
// - new safing threshold in diagnostic also loads the tally.
// - tally saturates at 0xF against further increments.
// - tally saturates at 0x0 against further decrements.
// - challenge is 4-bit; question event on challenge register read.
// - spi fault on challenge read frame suppresses question event.
// - multi-answer response is four bytes, byte 3 down to byte 0.
// - countdown set to 0x3 entering window one, drops per byte.
// - single-answer mode takes one byte; countdown stays 0x1.
// - answer-mode select 1 means single-answer, 0 multi-answer.
// - every time-out starts a new sequence run on the next clock.
`ifndef QAWFC_CONSTS_SVH
`define QAWFC_CONSTS_SVH
`define QAWFC_TALLY_RST   4'h5
`define QAWFC_TALLY_MAX   4'hF
`define QAWFC_TALLY_MIN   4'h0
`define QAWFC_STEP        4'h1
`define QAWFC_CNT_MULTI   2'h3
`define QAWFC_CNT_SINGLE  2'h1
`define QAWFC_CNT_STEP    2'h1
`define QAWFC_CNT_ZERO    2'h0
`endif

//--- hw/qawfc_pkg.sv
package qawfc_pkg;
  typedef enum logic [2:0] {
    QAWFC_ST_OTHER,
    QAWFC_ST_DIAG,
    QAWFC_ST_ACTIVE,
    QAWFC_ST_SAFE
  } qawfc_dev_state_t;
  typedef enum logic [1:0] {
    QAWFC_GO_NONE,
    QAWFC_GO_RESET,
    QAWFC_GO_SAFE
  } qawfc_req_t;
endpackage

//--- testbench/qawfc_mcu_model.sv
`timescale 1ns/1ps
module qawfc_mcu_model (
  input  wire logic       i_clk,
  output logic            o_rd,
  output logic            o_fault,
  output logic            o_wr,
  output logic      [7:0] o_byte
);
  initial begin
    o_rd    = 1'b0;
    o_fault = 1'b0;
    o_wr    = 1'b0;
    o_byte  = 8'h00;
  end
  // challenge register read frame, fault flagged in the same cycle as the read strobe
  task automatic read_q(input logic f);
    @(negedge i_clk);
    o_rd    = 1'b1;
    o_fault = f;
    @(negedge i_clk);
    o_rd    = 1'b0;
    o_fault = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  // one response byte per write, sent highest byte first
  task automatic send(input logic [7:0] b);
    @(negedge i_clk);
    o_wr   = 1'b1;
    o_byte = b;
    @(negedge i_clk);
    o_wr   = 1'b0;
    o_byte = ~b;
    repeat (2) @(negedge i_clk);
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk, rst, sde, rfe, ms, wr, rd, flt;
  logic [2:0]  st;
  logic [8:0]  pv;
  logic [3:0]  sd, rdat, cv, tal, sth, rth, ocv;
  logic [7:0]  rb;
  logic [1:0]  sreq, cnt;
  logic [31:0] word;
  logic        fs, sf, rf, na, spin, mcu_reset_n_pin, nr, qe, fin;
  int          error_cnt, cmp_count, nr_n, q_n, f_n, rr_n, rs_n;
  qawfc_mcu_model mcu (.i_clk(clk), .o_rd(rd), .o_fault(flt), .o_wr(wr), .o_byte(rb));
  qawfc_top dut (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_DEV_STATE(st), .I_CORRECT_ANSWER(pv[0]),
    .I_WRONG_ANSWER(pv[1]), .I_TIME_OUT(pv[2]), .I_CFG_CHANGE(pv[3]),
    .I_ANSWER_MODE_SEL(ms), .I_SAFING_DRIVE_ENABLE(sde), .I_RESET_ON_FAIL_ENABLE(rfe),
    .I_SAFE_EXIT(pv[7]), .I_SAFING_TH_WR(pv[5]), .I_SAFING_TH_DATA(sd),
    .I_RESET_TH_WR(pv[6]), .I_RESET_TH_DATA(rdat), .I_CHALLENGE_RD(rd), .I_SPI_FAULT(flt),
    .I_CHALLENGE_VALUE(cv), .I_WIN1_ENTER(pv[4]), .I_RESPONSE_WR(wr), .I_RESPONSE_BYTE(rb),
    .I_NO_ANSWER_CLR(pv[8]), .O_FAILURE_TALLY(tal), .O_SAFING_THRESHOLD(sth),
    .O_RESET_THRESHOLD(rth), .O_FAIL_SEEN_FLAG(fs), .O_SAFING_FAIL_FLAG(sf),
    .O_RESET_FAIL_FLAG(rf), .O_NO_ANSWER_FLAG(na), .O_SAFING_DRIVE_PIN(spin),
    .O_MCU_RESET_N_PIN(mcu_reset_n_pin), .O_STATE_REQ(sreq), .O_NEW_RUN(nr), .O_QUESTION_EVENT(qe),
    .O_CHALLENGE_VALUE(ocv), .O_RESPONSE_COUNTDOWN(cnt), .O_RESPONSE_WORD(word),
    .O_FINAL_BYTE(fin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // one-cycle outputs are counted as they appear
  always @(posedge clk) begin
    nr_n <= nr_n + int'(nr === 1'b1);
    q_n  <= q_n + int'(qe === 1'b1);
    f_n  <= f_n + int'(fin === 1'b1);
    rr_n <= rr_n + int'(sreq === 2'h1);
    rs_n <= rs_n + int'(sreq === 2'h2);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // n pulses on one event line, each given time for pins to follow
  task automatic fire(input int idx, input int n);
    repeat (n) begin
      @(negedge clk);
      pv[idx] = 1'b1;
      @(negedge clk);
      pv[idx] = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst, sde, rfe, ms, pv, st, sd, rdat} = '0;
    {error_cnt, cmp_count, nr_n, q_n, f_n, rr_n, rs_n} = '0;
    cv  = 4'h5;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk({tal, sf, spin, mcu_reset_n_pin, cnt}, {4'h5, 1'b1, 1'b0, 1'b1, 2'h3});
    st = 3'h1;
    fire(0, 6);
    chk({tal, fs, sf}, {4'h0, 1'b0, 1'b0});
    chk(spin, 1'b0);
    sde = 1'b1;
    repeat (3) @(negedge clk);
    chk(spin, 1'b1);
    fire(1, 1);
    chk({tal, fs}, {4'h1, 1'b1});
    st = 3'h0;
    fire(1, 1);
    chk(tal, 4'h1);
    st = 3'h1;
    sd = 4'h3;
    fire(5, 1);
    chk({sth, tal, sf, spin}, {4'h3, 4'h3, 1'b1, 1'b0});
    rdat = 4'h6;
    rfe  = 1'b1;
    fire(6, 1);
    st = 3'h2;
    fire(2, 1);
    chk({tal, na, rf}, {4'h4, 1'b1, 1'b0});
    chk(nr_n, 1);
    fire(1, 2);
    chk({rth, tal, rf, mcu_reset_n_pin}, {4'h6, 4'h6, 1'b1, 1'b0});
    chk(rr_n, 1);
    fire(3, 10);
    chk(tal, 4'hF);
    chk(nr_n, 11);
    fire(1, 1);
    chk(tal, 4'hF);
    mcu.read_q(1'b1);
    chk({q_n[3:0], ocv}, {4'h0, 4'h0});
    cv = 4'hA;
    mcu.read_q(1'b0);
    chk({q_n[3:0], ocv}, {4'h1, 4'hA});
    fire(4, 1);
    chk(cnt, 2'h3);
    mcu.send(8'h11);
    mcu.send(8'h22);
    chk(cnt, 2'h1);
    mcu.send(8'h33);
    mcu.send(8'h44);
    chk({word, cnt, f_n[3:0]}, {32'h11223344, 2'h0, 4'h1});
    fire(4, 1);
    chk(cnt, 2'h3);
    ms = 1'b1;
    fire(4, 1);
    mcu.send(8'h5A);
    chk({word[7:0], cnt, f_n[3:0]}, {8'h5A, 2'h1, 4'h2});
    // reset threshold reached without reset-on-fail: safe request
    st   = 3'h1;
    rfe  = 1'b0;
    rdat = 4'hF;
    fire(6, 1);
    chk({rth, rf, mcu_reset_n_pin, rs_n[3:0]}, {4'hF, 1'b1, 1'b1, 4'h1});
    // parked in safe: reset request only after the safe-exit command
    st  = 3'h3;
    rfe = 1'b1;
    repeat (3) @(negedge clk);
    chk({rr_n[3:0], mcu_reset_n_pin}, {4'h1, 1'b0});
    fire(7, 1);
    chk(rr_n, 2);
    sd = 4'h9;
    fire(5, 1);
    chk({sth, tal}, {4'h3, 4'hF});
    fire(8, 1);
    chk(na, 1'b0);
    // time-out and clear together: set wins
    @(negedge clk);
    pv = 9'h104;
    @(negedge clk);
    pv = '0;
    repeat (2) @(negedge clk);
    chk(na, 1'b1);
    // reset again in mid-run
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({tal, sth, rth, na, rf, cnt}, {4'h5, 4'h5, 4'hF, 1'b0, 1'b0, 2'h3});
    wrap_up();
  end
endmodule
